// ---- src/acr_pkg.sv ----
// Package of offsets, field positions, reset values and timing for the amplifier control bank
package acr_pkg;

	// ---------------------------------------------------------------
	// Register offsets (page 0)
	// ---------------------------------------------------------------
	localparam logic [7:0] ACR_OFS_PAGE       = 8'h00;
	localparam logic [7:0] ACR_OFS_MODE_SENSE = 8'h02;
	localparam logic [7:0] ACR_OFS_SWITCHING  = 8'h03;
	localparam logic [7:0] ACR_OFS_SUPPLY     = 8'h04;
	localparam logic [7:0] ACR_OFS_FOLDBACK   = 8'h05;
	localparam logic [7:0] ACR_OFS_RETRY      = 8'h06;
	localparam logic [7:0] ACR_PAGE_ZERO      = 8'h00;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ACR_RST_PAGE       = 8'h00;
	localparam logic [7:0] ACR_RST_MODE_SENSE = 8'h1a;
	localparam logic [7:0] ACR_RST_SWITCHING  = 8'h28;
	localparam logic [7:0] ACR_RST_SUPPLY     = 8'h21;
	localparam logic [7:0] ACR_RST_FOLDBACK   = 8'h41;
	localparam logic [7:0] ACR_RST_RETRY      = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int ACR_BIT_BROWNOUT_SEL  = 7;
	localparam int ACR_BIT_CURRENT_PD    = 4;
	localparam int ACR_BIT_VOLTAGE_PD    = 3;
	localparam int ACR_MODE_MSB          = 2;
	localparam int ACR_SCHEME_MSB        = 7;
	localparam int ACR_SCHEME_LSB        = 6;
	localparam int ACR_LEVEL_MSB         = 5;
	localparam int ACR_LEVEL_LSB         = 1;
	localparam int ACR_BIT_LOW_SRC       = 7;
	localparam int ACR_BIT_PULLUP        = 6;
	localparam int ACR_BIT_SPREAD        = 5;
	localparam int ACR_CONV_MSB          = 4;
	localparam int ACR_CONV_LSB          = 3;
	localparam int ACR_DCB_MSB           = 2;
	localparam int ACR_BIT_FOLDBACK      = 3;
	localparam int ACR_BIT_OC_RETRY      = 5;
	localparam int ACR_BIT_OT_RETRY      = 4;
	localparam int ACR_BIT_POSTFILTER    = 3;
	localparam int ACR_BIT_SAFE          = 2;

	// ---------------------------------------------------------------
	// Operating modes and encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] ACR_MODE_ACTIVE   = 3'h0;
	localparam logic [2:0] ACR_MODE_MUTED    = 3'h1;
	localparam logic [2:0] ACR_MODE_SHUTDOWN = 3'h2;
	localparam logic [1:0] ACR_SCHEME_LOWPWR = 2'h3;
	localparam logic [2:0] ACR_DCB_RESERVED  = 3'h7;

	// ---------------------------------------------------------------
	// Retry timing
	// ---------------------------------------------------------------
	localparam longint ACR_CLK_HZ        = 10000000;
	localparam longint ACR_RETRY_MS      = 1500;
	localparam longint ACR_RETRY_CYCLES  = (ACR_RETRY_MS * ACR_CLK_HZ) / 1000;

	typedef enum logic [1:0] {
		ACR_RUN  = 2'b00,
		ACR_HOLD = 2'b01,
		ACR_WAIT = 2'b11
	} acr_fault_e;

endpackage : acr_pkg

// ---- src/acr_retry_timer.sv ----
// Fault retry timer that counts out the hold-off period
`timescale 1ns/1ns
`default_nettype none
module acr_retry_timer
	import acr_pkg::*;
#(
	parameter int unsigned RETRY_CYCLES = 32'(ACR_RETRY_CYCLES)
) (
	input  wire logic clk,     // Core clock
	input  wire logic rst,     // Async reset, high
	input  wire logic start,   // Restart the period
	output logic      expired  // Period has elapsed, level
);

	logic [31:0] count;
	logic [31:0] next_count;

	// Count down from the period; a start always restarts the full wait
	always_comb begin
		next_count = count;
		if (start) begin
			next_count = RETRY_CYCLES - 32'h1;
		end else if (count != 32'h0) begin
			next_count = count - 32'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 32'h0;
		end else begin
			count <= next_count;
		end
	end

	assign expired = (count == 32'h0) && !start;

endmodule : acr_retry_timer
`default_nettype wire

// ---- src/acr_core_regs.sv ----
// Page 0 control register bank of the amplifier core with its decoded settings
//
// Function
// - Mode field selects active, muted or shutdown
// - Bit 7 picks brownout supply and lockout
// - Switching scheme field, code 3 low power
// - Bit 7 tells low supply origin
// - Bit 6 enables interrupt line pull-up
// - Spread spectrum, overridden by clock sync
// - Converter filter off or three cut-offs
// - Playback DC blocker bypass or six cut-offs
// - Record DC blocker same coding, reset one
// - Overcurrent fault auto retry after timer
// - Overtemperature fault auto retry after timer
// - Feedback source: outputs or sense pins
// - Never retry before retry period elapses
// - Bank reachable only when page zero selected
`timescale 1ns/1ns
`default_nettype none
module acr_core_regs
	import acr_pkg::*;
#(
	parameter int unsigned RETRY_CYCLES = 32'(ACR_RETRY_CYCLES)
) (
	input  wire logic       CORE_CLK,          // Core clock, 10 MHz
	input  wire logic       RST,               // Async reset, high
	input  wire logic       WR_EN,             // Control port write strobe
	input  wire logic       RD_EN,             // Control port read strobe
	input  wire logic [7:0] ADDR,              // Register offset
	input  wire logic [7:0] WDATA,             // Write data
	input  wire logic       CLOCK_SYNC,        // Class-D sync to audio clocks
	input  wire logic       OVERCURRENT,       // Overcurrent fault, async level
	input  wire logic       OVERTEMP,          // Overtemperature fault, async level
	output logic [7:0]      RDATA,             // Read data
	output logic            RVALID,            // Read data valid pulse
	output logic            AMP_ENABLE,        // Class-D running
	output logic            AMP_MUTE,          // Audio muted
	output logic            SHUTDOWN,          // Software or fault shutdown in force
	output logic            BROWNOUT_INPUT_SELECT,  // Brownout monitors high supply
	output logic            HIGH_SUPPLY_LOCKOUT,    // High supply lockout enabled
	output logic            CURRENT_SENSE_POWERDOWN, // Current sense off
	output logic            VOLTAGE_SENSE_POWERDOWN, // Voltage sense off
	output logic [1:0]      SWITCHING_SUPPLY_SCHEME, // Class-D supply scheme
	output logic            LOW_POWER_BRIDGE,  // Low-power dual supply mode
	output logic [4:0]      AMP_LEVEL,         // Amplifier level code
	output logic            LOW_SUPPLY_SOURCE, // Low supply made internally
	output logic            INTERRUPT_LINE_PULLUP, // Pull-up on interrupt line
	output logic            SPREAD_SPECTRUM,   // Effective spread spectrum
	output logic [1:0]      CONVERTER_FILTER_CUTOFF, // Converter filter code
	output logic            CONVERTER_FILTER_ON, // Converter filter in use
	output logic [2:0]      PLAYBACK_DC_BLOCK_CUTOFF, // Playback blocker code
	output logic            PLAYBACK_DC_BLOCK_ON, // Playback blocker in path
	output logic            THERMAL_FOLDBACK_ENABLE, // Thermal foldback on
	output logic [2:0]      RECORD_DC_BLOCK_CUTOFF, // Record blocker code
	output logic            RECORD_DC_BLOCK_ON, // Record blocker in path
	output logic            POSTFILTER_FEEDBACK_ENABLE, // Feedback from sense pins
	output logic            SAFE_MODE,         // Safe mode on
	output logic            FAULT_SHUTDOWN     // Held off by a fault
);

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	logic [7:0] page;
	logic [7:0] mode_and_sense_control;
	logic [7:0] output_switching_and_level;
	logic [7:0] supply_and_filter_config;
	logic [7:0] foldback_and_record_filter;
	logic [7:0] fault_retry_and_feedback;
	logic [7:0] next_page;
	logic [7:0] next_mode_and_sense_control;
	logic [7:0] next_output_switching_and_level;
	logic [7:0] next_supply_and_filter_config;
	logic [7:0] next_foldback_and_record_filter;
	logic [7:0] next_fault_retry_and_feedback;
	logic [7:0] next_rdata;
	logic       next_rvalid;
	logic       page_zero;

	// Bank is only decoded while page zero is selected
	assign page_zero = (page == ACR_PAGE_ZERO);

	// Write decode; every bit, reserved ones too, is stored as written
	always_comb begin
		next_page                       = page;
		next_mode_and_sense_control     = mode_and_sense_control;
		next_output_switching_and_level = output_switching_and_level;
		next_supply_and_filter_config   = supply_and_filter_config;
		next_foldback_and_record_filter = foldback_and_record_filter;
		next_fault_retry_and_feedback   = fault_retry_and_feedback;
		if (WR_EN) begin
			if (ADDR == ACR_OFS_PAGE) begin
				next_page = WDATA;
			end else if (page_zero) begin
				case (ADDR)
					ACR_OFS_MODE_SENSE: next_mode_and_sense_control     = WDATA;
					ACR_OFS_SWITCHING:  next_output_switching_and_level = WDATA;
					ACR_OFS_SUPPLY:     next_supply_and_filter_config   = WDATA;
					ACR_OFS_FOLDBACK:   next_foldback_and_record_filter = WDATA;
					ACR_OFS_RETRY:      next_fault_retry_and_feedback   = WDATA;
					default: begin
					end
				endcase
			end
		end
	end

	// Read mux; bank offsets on other pages and unmapped offsets read as zero
	always_comb begin
		next_rdata  = 8'h00;
		next_rvalid = RD_EN;
		if (RD_EN) begin
			if (ADDR == ACR_OFS_PAGE) begin
				next_rdata = page;
			end else if (page_zero) begin
				case (ADDR)
					ACR_OFS_MODE_SENSE: next_rdata = mode_and_sense_control;
					ACR_OFS_SWITCHING:  next_rdata = output_switching_and_level;
					ACR_OFS_SUPPLY:     next_rdata = supply_and_filter_config;
					ACR_OFS_FOLDBACK:   next_rdata = foldback_and_record_filter;
					ACR_OFS_RETRY:      next_rdata = fault_retry_and_feedback;
					default:            next_rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			page                       <= ACR_RST_PAGE;
			mode_and_sense_control     <= ACR_RST_MODE_SENSE;
			output_switching_and_level <= ACR_RST_SWITCHING;
			supply_and_filter_config   <= ACR_RST_SUPPLY;
			foldback_and_record_filter <= ACR_RST_FOLDBACK;
			fault_retry_and_feedback   <= ACR_RST_RETRY;
			RDATA                      <= 8'h00;
			RVALID                     <= 1'b0;
		end else begin
			page                       <= next_page;
			mode_and_sense_control     <= next_mode_and_sense_control;
			output_switching_and_level <= next_output_switching_and_level;
			supply_and_filter_config   <= next_supply_and_filter_config;
			foldback_and_record_filter <= next_foldback_and_record_filter;
			fault_retry_and_feedback   <= next_fault_retry_and_feedback;
			RDATA                      <= next_rdata;
			RVALID                     <= next_rvalid;
		end
	end

	// ---------------------------------------------------------------
	// Fault synchronisers and retry hold-off
	// ---------------------------------------------------------------
	logic [1:0] oc_sync;
	logic [1:0] ot_sync;
	logic       oc_flt;
	logic       ot_flt;
	acr_fault_e fstate;
	acr_fault_e next_fstate;
	logic       oc_seen;
	logic       next_oc_seen;
	logic       timer_start;
	logic       timer_expired;
	logic       retry_allowed;

	// Two flops per fault pin; only the second stage is looked at
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			oc_sync <= 2'b00;
			ot_sync <= 2'b00;
		end else begin
			oc_sync <= {oc_sync[0], OVERCURRENT};
			ot_sync <= {ot_sync[0], OVERTEMP};
		end
	end
	assign oc_flt = oc_sync[1];
	assign ot_flt = ot_sync[1];

	acr_retry_timer #(
		.RETRY_CYCLES(RETRY_CYCLES)
	) u_timer (
		.clk    (CORE_CLK),
		.rst    (RST),
		.start  (timer_start),
		.expired(timer_expired)
	);

	// Retry needs the bit for the fault that struck
	assign retry_allowed = oc_seen ? fault_retry_and_feedback[ACR_BIT_OC_RETRY]
	                               : fault_retry_and_feedback[ACR_BIT_OT_RETRY];

	// Latched faults leave HOLD only through a shutdown request, and even
	// then wait out the timer, so the stage is never stressed in quick bursts
	always_comb begin
		next_fstate  = fstate;
		next_oc_seen = oc_seen;
		timer_start  = 1'b0;
		case (fstate)
			ACR_RUN: begin
				if (oc_flt || ot_flt) begin
					next_fstate  = ACR_HOLD;
					next_oc_seen = oc_flt;
					timer_start  = 1'b1;
				end
			end
			ACR_HOLD: begin
				if (oc_flt || ot_flt) begin
					timer_start = 1'b1;
				end else if (retry_allowed ||
				             mode_and_sense_control[ACR_MODE_MSB:0] == ACR_MODE_SHUTDOWN) begin
					next_fstate = ACR_WAIT;
				end
			end
			ACR_WAIT: begin
				if (oc_flt || ot_flt) begin
					next_fstate = ACR_HOLD;
					timer_start = 1'b1;
				end else if (timer_expired) begin
					next_fstate = ACR_RUN;
				end
			end
			default: next_fstate = ACR_RUN;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			fstate  <= ACR_RUN;
			oc_seen <= 1'b0;
		end else begin
			fstate  <= next_fstate;
			oc_seen <= next_oc_seen;
		end
	end

	// ---------------------------------------------------------------
	// Decoded settings, all registered
	// ---------------------------------------------------------------
	logic [2:0] mode;
	logic       run_ok;
	assign mode   = mode_and_sense_control[ACR_MODE_MSB:0];
	assign run_ok = (next_fstate == ACR_RUN);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			AMP_ENABLE                 <= 1'b0;
			AMP_MUTE                   <= 1'b1;
			SHUTDOWN                   <= 1'b1;
			FAULT_SHUTDOWN             <= 1'b0;
			BROWNOUT_INPUT_SELECT      <= 1'b0;
			HIGH_SUPPLY_LOCKOUT        <= 1'b0;
			CURRENT_SENSE_POWERDOWN    <= 1'b1;
			VOLTAGE_SENSE_POWERDOWN    <= 1'b1;
			SWITCHING_SUPPLY_SCHEME    <= 2'h0;
			LOW_POWER_BRIDGE           <= 1'b0;
			AMP_LEVEL                  <= ACR_RST_SWITCHING[ACR_LEVEL_MSB:ACR_LEVEL_LSB];
			LOW_SUPPLY_SOURCE          <= 1'b0;
			INTERRUPT_LINE_PULLUP      <= 1'b0;
			SPREAD_SPECTRUM            <= 1'b0;
			CONVERTER_FILTER_CUTOFF    <= 2'h0;
			CONVERTER_FILTER_ON        <= 1'b0;
			PLAYBACK_DC_BLOCK_CUTOFF   <= ACR_RST_SUPPLY[ACR_DCB_MSB:0];
			PLAYBACK_DC_BLOCK_ON       <= 1'b0;
			THERMAL_FOLDBACK_ENABLE    <= 1'b0;
			RECORD_DC_BLOCK_CUTOFF     <= ACR_RST_FOLDBACK[ACR_DCB_MSB:0];
			RECORD_DC_BLOCK_ON         <= 1'b0;
			POSTFILTER_FEEDBACK_ENABLE <= 1'b0;
			SAFE_MODE                  <= 1'b0;
		end else begin
			// Reserved mode codes are treated as shutdown for safety
			AMP_ENABLE <= run_ok && (mode == ACR_MODE_ACTIVE || mode == ACR_MODE_MUTED);
			AMP_MUTE   <= !(run_ok && mode == ACR_MODE_ACTIVE);
			SHUTDOWN   <= !run_ok || !(mode == ACR_MODE_ACTIVE || mode == ACR_MODE_MUTED);
			FAULT_SHUTDOWN          <= !run_ok;
			BROWNOUT_INPUT_SELECT   <= mode_and_sense_control[ACR_BIT_BROWNOUT_SEL];
			HIGH_SUPPLY_LOCKOUT     <= mode_and_sense_control[ACR_BIT_BROWNOUT_SEL];
			CURRENT_SENSE_POWERDOWN <= mode_and_sense_control[ACR_BIT_CURRENT_PD];
			VOLTAGE_SENSE_POWERDOWN <= mode_and_sense_control[ACR_BIT_VOLTAGE_PD];
			SWITCHING_SUPPLY_SCHEME <= output_switching_and_level[ACR_SCHEME_MSB:ACR_SCHEME_LSB];
			LOW_POWER_BRIDGE        <= output_switching_and_level[ACR_SCHEME_MSB:ACR_SCHEME_LSB]
			                           == ACR_SCHEME_LOWPWR;
			AMP_LEVEL               <= output_switching_and_level[ACR_LEVEL_MSB:ACR_LEVEL_LSB];
			LOW_SUPPLY_SOURCE       <= supply_and_filter_config[ACR_BIT_LOW_SRC];
			INTERRUPT_LINE_PULLUP   <= supply_and_filter_config[ACR_BIT_PULLUP];
			// Sync to audio clocks takes priority over spreading
			SPREAD_SPECTRUM         <= supply_and_filter_config[ACR_BIT_SPREAD] && !CLOCK_SYNC;
			CONVERTER_FILTER_CUTOFF <= supply_and_filter_config[ACR_CONV_MSB:ACR_CONV_LSB];
			CONVERTER_FILTER_ON     <= supply_and_filter_config[ACR_CONV_MSB:ACR_CONV_LSB] != 2'h0;
			PLAYBACK_DC_BLOCK_CUTOFF <= supply_and_filter_config[ACR_DCB_MSB:0];
			// Code 0 bypasses; reserved code 7 also bypasses rather than guessing
			PLAYBACK_DC_BLOCK_ON    <= supply_and_filter_config[ACR_DCB_MSB:0] != 3'h0 &&
			                           supply_and_filter_config[ACR_DCB_MSB:0] != ACR_DCB_RESERVED;
			THERMAL_FOLDBACK_ENABLE <= foldback_and_record_filter[ACR_BIT_FOLDBACK];
			RECORD_DC_BLOCK_CUTOFF  <= foldback_and_record_filter[ACR_DCB_MSB:0];
			RECORD_DC_BLOCK_ON      <= foldback_and_record_filter[ACR_DCB_MSB:0] != 3'h0 &&
			                           foldback_and_record_filter[ACR_DCB_MSB:0] != ACR_DCB_RESERVED;
			POSTFILTER_FEEDBACK_ENABLE <= fault_retry_and_feedback[ACR_BIT_POSTFILTER];
			SAFE_MODE               <= fault_retry_and_feedback[ACR_BIT_SAFE];
		end
	end

endmodule : acr_core_regs
`default_nettype wire

// ---- verification/acr_core_regs_monitor.sv ----
// Port checker of the amplifier control bank
`timescale 1ns/1ns
`default_nettype none
module acr_core_regs_monitor
	import acr_pkg::*;
#(
	parameter int unsigned RETRY_CYCLES = 32'(ACR_RETRY_CYCLES)
) (
	input wire logic       CORE_CLK,                 // Clock
	input wire logic       RST,                      // Reset
	input wire logic       WR_EN,                    // Write
	input wire logic       RD_EN,                    // Read
	input wire logic [7:0] ADDR,                     // Offset
	input wire logic [7:0] WDATA,                    // Write data
	input wire logic       CLOCK_SYNC,               // Sync
	input wire logic       OVERCURRENT,              // Fault
	input wire logic       OVERTEMP,                 // Fault
	input wire logic [7:0] RDATA,                    // Read data
	input wire logic       RVALID,                   // Read valid
	input wire logic       AMP_ENABLE,               // Running
	input wire logic       AMP_MUTE,                 // Muted
	input wire logic       SHUTDOWN,                 // Shut down
	input wire logic       BROWNOUT_INPUT_SELECT,    // Brownout
	input wire logic       HIGH_SUPPLY_LOCKOUT,      // Lockout
	input wire logic [1:0] SWITCHING_SUPPLY_SCHEME,  // Scheme
	input wire logic       LOW_POWER_BRIDGE,         // Low power
	input wire logic       SPREAD_SPECTRUM,          // Spread
	input wire logic [2:0] PLAYBACK_DC_BLOCK_CUTOFF, // Blocker code
	input wire logic       PLAYBACK_DC_BLOCK_ON,     // Blocker on
	input wire logic       FAULT_SHUTDOWN            // Held off
);
	// ---------------------------------------------------------------
	// Helper state
	// ---------------------------------------------------------------
	logic [7:0]  page;
	logic [7:0]  next_page;
	logic        settled;
	int unsigned quiet;
	int unsigned next_quiet;
	logic        w02;
	logic        in_bank;

	// Page copy and quiet count; the count saturates so long idle never wraps
	always_comb begin
		next_page = (WR_EN && ADDR == ACR_OFS_PAGE) ? WDATA : page;
		next_quiet = (OVERCURRENT || OVERTEMP) ? 0 : ((quiet == 32'hffffffff) ? quiet : quiet + 1);
	end

	// Settled masks the first edge, where outputs still hold reset levels
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			page <= 8'h00;
			settled <= 1'b0;
			quiet <= 0;
		end else begin
			page <= next_page;
			settled <= 1'b1;
			quiet <= next_quiet;
		end
	end

	assign w02 = WR_EN && ADDR == ACR_OFS_MODE_SENSE && page == ACR_PAGE_ZERO;
	assign in_bank = ADDR >= ACR_OFS_MODE_SENSE && ADDR <= ACR_OFS_RETRY;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	a_read_valid_pulse: assert property (RD_EN |=> RVALID)
		else $error("read not answered one cycle later");
	a_rdata_idle_zero: assert property (!RD_EN |=> !RVALID && RDATA == 8'h00)
		else $error("read data left standing");
	a_page_gate_read: assert property (RD_EN && page != ACR_PAGE_ZERO && in_bank |=> RDATA == 8'h00)
		else $error("bank read while another page selected");
	a_mode_active_run: assert property (w02 && WDATA[2:0] == ACR_MODE_ACTIVE |-> ##2
		(FAULT_SHUTDOWN || (AMP_ENABLE && !AMP_MUTE && !SHUTDOWN)))
		else $error("active mode write did not start the amplifier");
	a_brownout_follow: assert property (w02 |-> ##2
		(BROWNOUT_INPUT_SELECT == $past(WDATA[7], 2) && HIGH_SUPPLY_LOCKOUT == $past(WDATA[7], 2)))
		else $error("brownout select does not follow write");
	a_low_power_bridge: assert property (LOW_POWER_BRIDGE == (SWITCHING_SUPPLY_SCHEME == ACR_SCHEME_LOWPWR))
		else $error("low power bridge decode wrong");
	a_spread_sync_wins: assert property ($past(CLOCK_SYNC) |-> !SPREAD_SPECTRUM)
		else $error("spread spectrum on while synced");
	a_dcblock_bypass: assert property (settled |-> PLAYBACK_DC_BLOCK_ON ==
		(PLAYBACK_DC_BLOCK_CUTOFF != 3'h0 && PLAYBACK_DC_BLOCK_CUTOFF != ACR_DCB_RESERVED))
		else $error("blocker enable decode wrong");
	a_fault_entry_fast: assert property ($rose(OVERCURRENT) |-> ##[1:4] FAULT_SHUTDOWN)
		else $error("overcurrent did not shut down");
	a_fault_holdoff_time: assert property ($fell(FAULT_SHUTDOWN) |-> quiet >= RETRY_CYCLES)
		else $error("retry before hold-off elapsed");

	c_page_other: cover property (RD_EN && page != ACR_PAGE_ZERO && in_bank);
	c_mode_write: cover property (w02);
	c_fault_release: cover property ($fell(FAULT_SHUTDOWN));
endmodule : acr_core_regs_monitor

bind acr_core_regs acr_core_regs_monitor #(.RETRY_CYCLES(RETRY_CYCLES)) acr_core_regs_monitor_i (
	.CORE_CLK(CORE_CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
	.CLOCK_SYNC(CLOCK_SYNC), .OVERCURRENT(OVERCURRENT), .OVERTEMP(OVERTEMP), .RDATA(RDATA),
	.RVALID(RVALID), .AMP_ENABLE(AMP_ENABLE), .AMP_MUTE(AMP_MUTE), .SHUTDOWN(SHUTDOWN),
	.BROWNOUT_INPUT_SELECT(BROWNOUT_INPUT_SELECT), .HIGH_SUPPLY_LOCKOUT(HIGH_SUPPLY_LOCKOUT),
	.SWITCHING_SUPPLY_SCHEME(SWITCHING_SUPPLY_SCHEME), .LOW_POWER_BRIDGE(LOW_POWER_BRIDGE),
	.SPREAD_SPECTRUM(SPREAD_SPECTRUM), .PLAYBACK_DC_BLOCK_CUTOFF(PLAYBACK_DC_BLOCK_CUTOFF),
	.PLAYBACK_DC_BLOCK_ON(PLAYBACK_DC_BLOCK_ON), .FAULT_SHUTDOWN(FAULT_SHUTDOWN)
);
`default_nettype wire

// ---- verification/acr_core_regs_tb.sv ----
// Self-checking bench of the amplifier control bank
`timescale 1ns/1ns
`default_nettype none
module acr_core_regs_tb
	import acr_pkg::*;
;
	// ---------------------------------------------------------------
	// Stimulus, outputs and model
	// ---------------------------------------------------------------
	localparam int RC = 20;
	logic        CORE_CLK, RST, WR_EN, RD_EN, CLOCK_SYNC, OVERCURRENT, OVERTEMP;
	logic [7:0]  ADDR, WDATA, mpage;
	logic [7:0]  mreg [0:6];
	wire  [7:0]  RDATA;
	wire         RVALID;
	wire  [32:0] ob;
	int          n_fail, compares;

	acr_core_regs #(.RETRY_CYCLES(RC)) acr_core_regs_i (
		.CORE_CLK(CORE_CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
		.CLOCK_SYNC(CLOCK_SYNC), .OVERCURRENT(OVERCURRENT), .OVERTEMP(OVERTEMP), .RDATA(RDATA),
		.RVALID(RVALID), .AMP_ENABLE(ob[32]), .AMP_MUTE(ob[31]), .SHUTDOWN(ob[30]),
		.BROWNOUT_INPUT_SELECT(ob[29]), .HIGH_SUPPLY_LOCKOUT(ob[28]), .CURRENT_SENSE_POWERDOWN(ob[27]),
		.VOLTAGE_SENSE_POWERDOWN(ob[26]), .SWITCHING_SUPPLY_SCHEME(ob[25:24]), .LOW_POWER_BRIDGE(ob[23]),
		.AMP_LEVEL(ob[22:18]), .LOW_SUPPLY_SOURCE(ob[17]), .INTERRUPT_LINE_PULLUP(ob[16]),
		.SPREAD_SPECTRUM(ob[15]), .CONVERTER_FILTER_CUTOFF(ob[14:13]), .CONVERTER_FILTER_ON(ob[12]),
		.PLAYBACK_DC_BLOCK_CUTOFF(ob[11:9]), .PLAYBACK_DC_BLOCK_ON(ob[8]), .THERMAL_FOLDBACK_ENABLE(ob[7]),
		.RECORD_DC_BLOCK_CUTOFF(ob[6:4]), .RECORD_DC_BLOCK_ON(ob[3]), .POSTFILTER_FEEDBACK_ENABLE(ob[2]),
		.SAFE_MODE(ob[1]), .FAULT_SHUTDOWN(ob[0])
	);

	// Free-running 10 MHz clock
	initial begin
		CORE_CLK = 1'b0;
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Decoded outputs expected from the model; reserved mode codes count as shutdown
	function automatic logic [32:0] expect_out();
		logic [2:0] m;
		logic [7:0] c;
		m = mreg[2][2:0];
		c = mreg[4];
		return {m <= 3'h1, m != ACR_MODE_ACTIVE, m > 3'h1, mreg[2][7], mreg[2][7], mreg[2][4:3],
			mreg[3][7:6], mreg[3][7:6] == 2'h3, mreg[3][5:1], c[7:6], c[5] & ~CLOCK_SYNC, c[4:3],
			c[4:3] != 2'h0, c[2:0], c[2:0] != 3'h0 && c[2:0] != 3'h7, mreg[5][3:0],
			mreg[5][2:0] != 3'h0 && mreg[5][2:0] != 3'h7, mreg[6][3:2], 1'b0};
	endfunction : expect_out

	task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		WR_EN <= 1'b1;
		ADDR  <= a;
		WDATA <= d;
		@(posedge CORE_CLK);
		WR_EN <= 1'b0;
		if (a == 8'h00)
			mpage = d;
		else if (a >= 8'h02 && a <= 8'h06 && mpage == 8'h00)
			mreg[a[2:0]] = d;
	endtask : wr

	// Other pages hide the bank; unmapped offsets read zero
	task automatic rd(input logic [7:0] a);
		logic [7:0] x;
		x = 8'h00;
		if (a == 8'h00)
			x = mpage;
		else if (a >= 8'h02 && a <= 8'h06 && mpage == 8'h00)
			x = mreg[a[2:0]];
		@(posedge CORE_CLK);
		RD_EN <= 1'b1;
		ADDR  <= a;
		@(posedge CORE_CLK);
		RD_EN <= 1'b0;
		#1;
		cmp("read", {24'h0, 1'b1, x}, {24'h0, RVALID, RDATA});
	endtask : rd

	task automatic chk();
		@(posedge CORE_CLK);
		#1;
		cmp("outputs", expect_out(), ob);
	endtask : chk

	// Bounded wait for the hold-off flag
	task automatic wait_fs(input logic tgt, output int n);
		n = 0;
		while (ob[0] !== tgt && n < 200) begin
			@(posedge CORE_CLK);
			#1;
			n++;
		end
	endtask : wait_fs

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		int n;
		logic [31:0] r;
		RST = 1'b1;
		WR_EN = 1'b0;
		RD_EN = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		CLOCK_SYNC = 1'b0;
		OVERCURRENT = 1'b0;
		OVERTEMP = 1'b0;
		n_fail = 0;
		compares = 0;
		r = 32'hdd68;
		mpage = 8'h00;
		mreg = '{8'h00, 8'h00, 8'h1a, 8'h28, 8'h21, 8'h41, 8'h00};
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		// Reset values, unmapped offsets and a dropped write
		for (int a = 0; a < 8; a++)
			rd(8'(a));
		wr(8'hff, 8'hff);
		rd(8'hff);
		chk;
		// Every mode, scheme, filter and blocker code, random remaining bits
		for (int i = 0; i < 8; i++) begin
			r = lfsr(r);
			wr(8'h02, {r[7:3], 3'(i)});
			// Changed on the write edge so it meets the design at a rising edge
			CLOCK_SYNC <= r[8];
			wr(8'h03, {2'(i), r[5:0]});
			wr(8'h04, {r[15:13], 2'(i), 3'(i)});
			wr(8'h05, {r[23:19], 3'(7 - i)});
			wr(8'h06, r[31:24]);
			for (int a = 2; a < 7; a++)
				rd(8'(a));
			chk;
		end
		// Bank hidden while another page is selected
		wr(8'h00, 8'h01);
		wr(8'h02, 8'h00);
		rd(8'h02);
		rd(8'h00);
		wr(8'h00, 8'h00);
		rd(8'h02);
		// Auto retry after each fault kind
		for (int f = 0; f < 2; f++) begin
			wr(8'h06, (f == 0) ? 8'h20 : 8'h10);
			wr(8'h02, 8'h18);
			OVERCURRENT <= (f == 0);
			OVERTEMP <= (f == 1);
			wait_fs(1'b1, n);
			cmp("fault entry", 33'(n <= 6), 33'h1);
			cmp("fault stop", 33'({ob[32], ob[30]}), 33'h1);
			repeat (3) @(posedge CORE_CLK);
			OVERCURRENT <= 1'b0;
			OVERTEMP <= 1'b0;
			wait_fs(1'b0, n);
			cmp("retry delay", 33'(n >= RC && n <= RC + 20), 33'h1);
			chk;
		end
		// Latched fault released only by a shutdown write
		wr(8'h06, 8'h00);
		OVERTEMP <= 1'b1;
		wait_fs(1'b1, n);
		@(posedge CORE_CLK);
		OVERTEMP <= 1'b0;
		repeat (RC + 20) @(posedge CORE_CLK);
		#1;
		cmp("latched", {32'h0, ob[0]}, 33'h1);
		wr(8'h02, 8'h1a);
		wait_fs(1'b0, n);
		cmp("latched release", 33'(n <= RC + 20), 33'h1);
		chk;
		print_verdict;
	end

	// Watchdog well past the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_fail++;
		print_verdict;
	end
endmodule : acr_core_regs_tb
`default_nettype wire
